/* shared/instr_exec_pkg.sv */
`default_nettype none
package instr_exec_pkg;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int unsigned PC_W        = 11;
   localparam int unsigned MEM_DEPTH   = 96;
   localparam int unsigned MEM_AW      = 7;
   localparam int unsigned PROG_W      = 15;
   localparam int unsigned STACK_DEPTH = 6;
   localparam int unsigned SP_W        = 3;
   localparam int unsigned TABLE_HIGH_BYTE_W      = 7;
   localparam int unsigned OP_W        = 5;

   // ----------------------------------------------------------------
   // Operation codes on the instruction port
   // ----------------------------------------------------------------
   localparam logic [OP_W-1:0] OP_NOP      = 5'h00;
   localparam logic [OP_W-1:0] OP_AND_TO_MEMORY_INSTR     = 5'h01;
   localparam logic [OP_W-1:0] OP_ANDI     = 5'h02;
   localparam logic [OP_W-1:0] OP_ANDA     = 5'h03;
   localparam logic [OP_W-1:0] OP_ADD_TO_MEMORY_INSTR     = 5'h04;
   localparam logic [OP_W-1:0] OP_ADDI     = 5'h05;
   localparam logic [OP_W-1:0] OP_ADDA     = 5'h06;
   localparam logic [OP_W-1:0] OP_ADD_CARRY_TO_MEMORY_INSTR     = 5'h07;
   localparam logic [OP_W-1:0] OP_ADCA     = 5'h08;
   localparam logic [OP_W-1:0] OP_INC_SKIP = 5'h09;
   localparam logic [OP_W-1:0] OP_DEC_SKIP = 5'h0a;
   localparam logic [OP_W-1:0] OP_SWAP_ACC = 5'h0b;
   localparam logic [OP_W-1:0] OP_HALT     = 5'h0c;
   localparam logic [OP_W-1:0] OP_WDOG_CLR = 5'h0d;
   localparam logic [OP_W-1:0] OP_WDOG_PC1 = 5'h0e;
   localparam logic [OP_W-1:0] OP_WDOG_PC2 = 5'h0f;
   localparam logic [OP_W-1:0] OP_CALL     = 5'h10;
   localparam logic [OP_W-1:0] OP_RET      = 5'h11;
   localparam logic [OP_W-1:0] OP_RET_IMM  = 5'h12;
   localparam logic [OP_W-1:0] OP_INT_RET  = 5'h13;
   localparam logic [OP_W-1:0] OP_TBL_CUR  = 5'h14;
   localparam logic [OP_W-1:0] OP_TBL_LAST = 5'h15;
   localparam logic [OP_W-1:0] OP_CLR_MEM  = 5'h16;

   // ----------------------------------------------------------------
   // Register port map
   // ----------------------------------------------------------------
   localparam logic [MEM_AW-1:0] PCL_ADDR    = 7'h06;
   localparam logic [MEM_AW-1:0] ACC_ADDR    = 7'h60;
   localparam logic [MEM_AW-1:0] STATUS_ADDR = 7'h61;
   localparam logic [MEM_AW-1:0] TABLE_HIGH_BYTE_ADDR   = 7'h62;
   localparam logic [MEM_AW-1:0] CTRL_ADDR   = 7'h63;

   // Status and control bit positions
   localparam int unsigned ST_C   = 0;
   localparam int unsigned ST_AC  = 1;
   localparam int unsigned ST_Z   = 2;
   localparam int unsigned ST_OV  = 3;
   localparam int unsigned ST_PDF = 4;
   localparam int unsigned ST_TO  = 5;
   localparam int unsigned CTRL_INT_EN = 0;

   // ----------------------------------------------------------------
   // Reset values and last table page
   // ----------------------------------------------------------------
   localparam logic [7:0]      ACC_RST    = 8'h00;
   localparam logic [5:0]      STATUS_RST = 6'h00;
   localparam logic [PC_W-1:0] PC_RST     = 11'h000;
   localparam logic [PC_W-1:0] LAST_PAGE  = 11'h700;
endpackage
`default_nettype wire

/* design/instr_exec.sv */
// Decided for this implementation: the plain strobed port and the address map.
`default_nettype none
// Contract
// RULE1: Skip instructions take two cycles when skipping, one cycle otherwise.
// RULE2: Any write of the program counter low byte costs two cycles.
// RULE3: Pre-clear pair executed back to back clears time-out and power-down flags.
// RULE4: Return with immediate pops address, loads accumulator, two cycles, flags kept.
// RULE5: Table read from current or last page; high part to table-high, two cycles.
// RULE6: Nibble swap of memory byte into accumulator, one cycle, flags kept.
// RULE7: Halt enters power-down in one cycle and updates time-out and power-down flags.
// RULE8: AND to memory writes result back, zero flag only.
// RULE9: AND immediate into accumulator, zero flag only.
// RULE10: AND from memory into accumulator, zero flag only.
// RULE11: Add to memory, updates overflow, zero, half carry and carry.
// RULE12: Add immediate into accumulator, updates the four arithmetic flags.
// RULE13: Add from memory into accumulator, updates the four arithmetic flags.
// RULE14: Add with carry to memory, updates the four arithmetic flags.
// RULE15: Add with carry into accumulator, updates the four arithmetic flags.
// RULE16: Memory plus one into accumulator, skip when zero, no flags.
// RULE17: Memory minus one into accumulator, skip when zero.
// RULE18: Watchdog clear resets counter and clears both flags at once.
// RULE19: Call pushes next address, jumps to target, two cycles.
// RULE20: Clear memory writes zero to the byte, flags kept.
// RULE21: Return and interrupt return pop the stack in two cycles; latter enables interrupts.
// RULE22: No-operation takes one cycle and changes nothing.
module instr_exec
   import instr_exec_pkg::*;
(
   input  wire logic              CLK_IN,
   input  wire logic              RST_B_IN,
   input  wire logic              INSTR_VALID_IN,
   input  wire logic [OP_W-1:0]   INSTR_OP_IN,
   input  wire logic [MEM_AW-1:0] INSTR_ADDR_IN,
   input  wire logic [7:0]        INSTR_IMM_IN,
   input  wire logic [PC_W-1:0]   INSTR_TARGET_IN,
   input  wire logic [PROG_W-1:0] TABLE_DATA_IN,
   input  wire logic              WAKE_IN,
   input  wire logic [MEM_AW-1:0] REG_ADDR_IN,
   input  wire logic [7:0]        REG_WDATA_IN,
   input  wire logic              REG_WR_IN,
   input  wire logic              REG_RD_IN,
   output logic [PC_W-1:0]        PC_OUT,
   output logic                   READY_OUT,
   output logic                   TABLE_RD_OUT,
   output logic [PC_W-1:0]        TABLE_ADDR_OUT,
   output logic                   WDT_CLEAR_OUT,
   output logic                   POWER_DOWN_OUT,
   output logic                   INT_ENABLE_OUT,
   output logic [7:0]             REG_RDATA_OUT
);
   typedef enum logic [1:0] {ST_EXEC, ST_SECOND, ST_TABLE, ST_SLEEP} state_e;

   state_e                state;
   state_e                next_state;
   logic [7:0]            mem [MEM_DEPTH];
   logic [7:0]            acc;
   logic [5:0]            status;
   logic [TABLE_HIGH_BYTE_W-1:0]     table_high_byte;
   logic [PC_W-1:0]       pc;
   logic [PC_W-1:0]       stack [STACK_DEPTH];
   logic [SP_W-1:0]       sp;
   logic                  preclear_first_seen;
   logic [MEM_AW-1:0]     table_dest;
   logic [2:0]            wake_sync;
   logic                  wake_level;

   logic                  go;
   logic [7:0]            mem_rd;
   logic [7:0]            operand;
   logic [8:0]            sum;
   logic                  half;
   logic [7:0]            inc_val;
   logic [7:0]            dec_val;
   logic [7:0]            next_acc;
   logic [5:0]            next_status;
   logic [PC_W-1:0]       next_pc;
   logic                  wr_en;
   logic [7:0]            wr_data;
   logic                  push;
   logic                  pop;
   logic                  next_preclear;
   logic                  wdt_clr;
   logic                  int_en_set;
   logic                  table_start;

   // ----------------------------------------------------------------
   // Operand fetch and adder
   // ----------------------------------------------------------------
   assign go = INSTR_VALID_IN && state == ST_EXEC;

   // Program counter low byte is mapped into data memory
   always_comb begin
      if (INSTR_ADDR_IN == PCL_ADDR) begin
         mem_rd = pc[7:0];
      end else if (INSTR_ADDR_IN < MEM_AW'(MEM_DEPTH)) begin
         mem_rd = mem[INSTR_ADDR_IN];
      end else begin
         mem_rd = 8'h00;
      end
   end

   assign operand = (INSTR_OP_IN == OP_ADDI) ? INSTR_IMM_IN : mem_rd;
   assign inc_val = mem_rd + 8'h01;
   assign dec_val = mem_rd - 8'h01;

   always_comb begin
      logic cin;
      cin  = 1'b0;
      if (INSTR_OP_IN == OP_ADD_CARRY_TO_MEMORY_INSTR || INSTR_OP_IN == OP_ADCA) begin
         cin = status[ST_C];
      end
      sum  = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
      half = ({1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin}) > 5'h0f;
   end

   // ----------------------------------------------------------------
   // Instruction decode
   // ----------------------------------------------------------------
   always_comb begin
      next_acc      = acc;
      next_status   = status;
      next_pc       = pc + 11'h001;
      next_state    = ST_EXEC;
      wr_en         = 1'b0;
      wr_data       = 8'h00;
      push          = 1'b0;
      pop           = 1'b0;
      next_preclear = 1'b0;
      wdt_clr       = 1'b0;
      int_en_set    = 1'b0;
      table_start   = 1'b0;
      case (INSTR_OP_IN)
         OP_AND_TO_MEMORY_INSTR: begin
            wr_en           = 1'b1;                                 // [RULE8]
            wr_data         = acc & mem_rd;
            next_status[ST_Z] = (acc & mem_rd) == 8'h00;
         end
         OP_ANDI: begin
            next_acc        = acc & INSTR_IMM_IN;                   // [RULE9]
            next_status[ST_Z] = (acc & INSTR_IMM_IN) == 8'h00;
         end
         OP_ANDA: begin
            next_acc        = acc & mem_rd;                         // [RULE10]
            next_status[ST_Z] = (acc & mem_rd) == 8'h00;
         end
         OP_ADD_TO_MEMORY_INSTR, OP_ADD_CARRY_TO_MEMORY_INSTR: begin
            wr_en   = 1'b1;                                         // [RULE11] [RULE14]
            wr_data = sum[7:0];
         end
         OP_ADDI, OP_ADDA, OP_ADCA: begin
            next_acc = sum[7:0];                                    // [RULE12] [RULE13] [RULE15]
         end
         OP_INC_SKIP: begin
            next_acc = inc_val;                                     // [RULE16]
            if (inc_val == 8'h00) begin
               next_pc    = pc + 11'h002;
               next_state = ST_SECOND;                              // [RULE1]
            end
         end
         OP_DEC_SKIP: begin
            next_acc = dec_val;                                     // [RULE17]
            if (dec_val == 8'h00) begin
               next_pc    = pc + 11'h002;
               next_state = ST_SECOND;                              // [RULE1]
            end
         end
         OP_SWAP_ACC: begin
            next_acc = {mem_rd[3:0], mem_rd[7:4]};                  // [RULE6]
         end
         OP_HALT: begin
            next_status[ST_PDF] = 1'b1;                             // [RULE7]
            next_status[ST_TO]  = 1'b0;
            wdt_clr             = 1'b1;
            next_state          = ST_SLEEP;
         end
         OP_WDOG_CLR: begin
            next_status[ST_PDF] = 1'b0;                             // [RULE18]
            next_status[ST_TO]  = 1'b0;
            wdt_clr             = 1'b1;
         end
         OP_WDOG_PC1: begin
            next_preclear = 1'b1;
         end
         OP_WDOG_PC2: begin
            // Only honoured straight after the first half
            if (preclear_first_seen) begin
               next_status[ST_PDF] = 1'b0;                          // [RULE3]
               next_status[ST_TO]  = 1'b0;
               wdt_clr             = 1'b1;
            end
         end
         OP_CALL: begin
            push       = 1'b1;                                      // [RULE19]
            next_pc    = INSTR_TARGET_IN;
            next_state = ST_SECOND;
         end
         OP_RET, OP_INT_RET: begin
            pop        = 1'b1;                                      // [RULE21]
            next_pc    = stack[sp - SP_W'(1)];
            next_state = ST_SECOND;
            int_en_set = INSTR_OP_IN == OP_INT_RET;
         end
         OP_RET_IMM: begin
            pop        = 1'b1;                                      // [RULE4]
            next_pc    = stack[sp - SP_W'(1)];
            next_acc   = INSTR_IMM_IN;
            next_state = ST_SECOND;
         end
         OP_TBL_CUR, OP_TBL_LAST: begin
            table_start = 1'b1;                                     // [RULE5]
            next_state  = ST_TABLE;
         end
         OP_CLR_MEM: begin
            wr_en   = 1'b1;                                         // [RULE20]
            wr_data = 8'h00;
         end
         default: begin
            next_acc = acc;                                         // [RULE22]
         end
      endcase
      if (INSTR_OP_IN == OP_ADD_TO_MEMORY_INSTR || INSTR_OP_IN == OP_ADD_CARRY_TO_MEMORY_INSTR || INSTR_OP_IN == OP_ADDI
          || INSTR_OP_IN == OP_ADDA || INSTR_OP_IN == OP_ADCA) begin
         next_status[ST_C]  = sum[8];
         next_status[ST_AC] = half;
         next_status[ST_Z]  = sum[7:0] == 8'h00;
         next_status[ST_OV] = (acc[7] == operand[7]) && (sum[7] != acc[7]);
      end
      // Writing the low program counter byte redirects flow
      if (wr_en && INSTR_ADDR_IN == PCL_ADDR) begin
         next_pc    = {pc[PC_W-1:8], wr_data};
         next_state = ST_SECOND;                                    // [RULE2]
      end
   end

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         state     <= ST_EXEC;
         READY_OUT <= 1'b1;
      end else if (state == ST_SLEEP) begin
         if (wake_level) begin
            state     <= ST_EXEC;
            READY_OUT <= 1'b1;
         end
      end else if (state != ST_EXEC) begin
         state     <= ST_EXEC;
         READY_OUT <= 1'b1;
      end else if (go) begin
         state     <= next_state;
         READY_OUT <= next_state == ST_EXEC;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         pc <= PC_RST;
      end else if (go) begin
         pc <= next_pc;
      end
   end

   // Pre-clear pairing: any other executed instruction breaks the pair
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         preclear_first_seen <= 1'b0;
      end else if (go) begin
         preclear_first_seen <= next_preclear;                      // [RULE3]
      end
   end

   // ----------------------------------------------------------------
   // Accumulator and status
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         acc <= ACC_RST;
      end else if (go) begin
         acc <= next_acc;
      end else if (REG_WR_IN && REG_ADDR_IN == ACC_ADDR) begin
         acc <= REG_WDATA_IN;
      end
   end

   // Software may not touch time-out and power-down bits
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         status <= STATUS_RST;
      end else if (go) begin
         status <= next_status;
      end else if (REG_WR_IN && REG_ADDR_IN == STATUS_ADDR) begin
         status[ST_OV:ST_C] <= REG_WDATA_IN[ST_OV:ST_C];
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         INT_ENABLE_OUT <= 1'b0;
      end else if (go && int_en_set) begin
         INT_ENABLE_OUT <= 1'b1;                                    // [RULE21]
      end else if (REG_WR_IN && REG_ADDR_IN == CTRL_ADDR) begin
         INT_ENABLE_OUT <= REG_WDATA_IN[CTRL_INT_EN];
      end
   end

   // ----------------------------------------------------------------
   // Return stack
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         sp <= '0;
      end else if (go && push && sp != SP_W'(STACK_DEPTH)) begin
         sp <= sp + SP_W'(1);
      end else if (go && pop && sp != '0) begin
         sp <= sp - SP_W'(1);
      end
   end

   // Overflowing pushes overwrite the top entry
   always_ff @(posedge CLK_IN) begin
      if (go && push) begin
         if (sp == SP_W'(STACK_DEPTH)) begin
            stack[STACK_DEPTH-1] <= pc + 11'h001;
         end else begin
            stack[sp] <= pc + 11'h001;                              // [RULE19]
         end
      end
   end

   // ----------------------------------------------------------------
   // Table read
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         TABLE_RD_OUT   <= 1'b0;
         TABLE_ADDR_OUT <= '0;
         table_dest     <= '0;
      end else begin
         TABLE_RD_OUT <= go && table_start;
         if (go && table_start) begin
            table_dest <= INSTR_ADDR_IN;
            if (INSTR_OP_IN == OP_TBL_LAST) begin
               TABLE_ADDR_OUT <= LAST_PAGE | {3'h0, INSTR_IMM_IN};  // [RULE5]
            end else begin
               TABLE_ADDR_OUT <= {pc[PC_W-1:8], INSTR_IMM_IN};
            end
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         table_high_byte <= '0;
      end else if (state == ST_TABLE) begin
         table_high_byte <= TABLE_DATA_IN[PROG_W-1:8];              // [RULE5]
      end
   end

   // ----------------------------------------------------------------
   // Data memory
   // ----------------------------------------------------------------
   // Instruction writes win over the register port in the same cycle
   always_ff @(posedge CLK_IN) begin
      if (go && wr_en && INSTR_ADDR_IN < MEM_AW'(MEM_DEPTH)) begin
         mem[INSTR_ADDR_IN] <= wr_data;
      end else if (state == ST_TABLE && table_dest < MEM_AW'(MEM_DEPTH)) begin
         mem[table_dest] <= TABLE_DATA_IN[7:0];
      end else if (REG_WR_IN && REG_ADDR_IN < MEM_AW'(MEM_DEPTH)) begin
         mem[REG_ADDR_IN] <= REG_WDATA_IN;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         REG_RDATA_OUT <= 8'h00;
      end else if (REG_RD_IN) begin
         if (REG_ADDR_IN == PCL_ADDR) begin
            REG_RDATA_OUT <= pc[7:0];
         end else if (REG_ADDR_IN < MEM_AW'(MEM_DEPTH)) begin
            REG_RDATA_OUT <= mem[REG_ADDR_IN];
         end else if (REG_ADDR_IN == ACC_ADDR) begin
            REG_RDATA_OUT <= acc;
         end else if (REG_ADDR_IN == STATUS_ADDR) begin
            REG_RDATA_OUT <= {2'h0, status};
         end else if (REG_ADDR_IN == TABLE_HIGH_BYTE_ADDR) begin
            REG_RDATA_OUT <= {1'h0, table_high_byte};
         end else if (REG_ADDR_IN == CTRL_ADDR) begin
            REG_RDATA_OUT <= {7'h00, INT_ENABLE_OUT};
         end else begin
            REG_RDATA_OUT <= 8'h00;
         end
      end else begin
         REG_RDATA_OUT <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Power-down, wake and watchdog clear
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         wake_sync  <= 3'h0;
         wake_level <= 1'b0;
      end else begin
         wake_sync <= {wake_sync[1:0], WAKE_IN};
         if (wake_sync[1] == wake_sync[2]) begin
            wake_level <= wake_sync[2];
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         POWER_DOWN_OUT <= 1'b0;
         WDT_CLEAR_OUT  <= 1'b0;
         PC_OUT         <= PC_RST;
      end else begin
         WDT_CLEAR_OUT <= go && wdt_clr;                            // [RULE18]
         PC_OUT        <= go ? next_pc : pc;
         if (go && INSTR_OP_IN == OP_HALT) begin
            POWER_DOWN_OUT <= 1'b1;                                 // [RULE7]
         end else if (state == ST_SLEEP && wake_level) begin
            POWER_DOWN_OUT <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* verif/instr_exec_asserts.sv */
`default_nettype none
module instr_exec_asserts
   import instr_exec_pkg::*;
(
   input wire logic              CLK_IN,
   input wire logic              RST_B_IN,
   input wire logic              INSTR_VALID_IN,
   input wire logic [OP_W-1:0]   INSTR_OP_IN,
   input wire logic [MEM_AW-1:0] INSTR_ADDR_IN,
   input wire logic [7:0]        INSTR_IMM_IN,
   input wire logic [PC_W-1:0]   INSTR_TARGET_IN,
   input wire logic [PC_W-1:0]   PC_OUT,
   input wire logic              READY_OUT,
   input wire logic              TABLE_RD_OUT,
   input wire logic [PC_W-1:0]   TABLE_ADDR_OUT,
   input wire logic              WDT_CLEAR_OUT,
   input wire logic              POWER_DOWN_OUT
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   wire logic            tk = INSTR_VALID_IN && READY_OUT;
   wire logic [OP_W-1:0] op = INSTR_OP_IN;
   // Memory writes aimed at the PC low byte act as jumps
   wire logic            pw = INSTR_ADDR_IN == PCL_ADDR && (op == OP_AND_TO_MEMORY_INSTR
                              || op == OP_ADD_TO_MEMORY_INSTR || op == OP_ADD_CARRY_TO_MEMORY_INSTR || op == OP_CLR_MEM);
   chk_call_jump:
   assert property (tk && op == OP_CALL |=> PC_OUT == $past(INSTR_TARGET_IN)
      && !READY_OUT ##1 READY_OUT) else $error("call timing");
   chk_return_len:
   assert property (tk && (op == OP_RET || op == OP_RET_IMM || op == OP_INT_RET)
      |=> !READY_OUT ##1 READY_OUT) else $error("return length");
   chk_table_pulse:
   assert property (tk && (op == OP_TBL_CUR || op == OP_TBL_LAST) |=> TABLE_RD_OUT
      && !READY_OUT ##1 !TABLE_RD_OUT && READY_OUT) else $error("table timing");
   chk_table_last:
   assert property (tk && op == OP_TBL_LAST
      |=> TABLE_ADDR_OUT == {3'h7, $past(INSTR_IMM_IN)}) else $error("table page");
   chk_halt_sleep:
   assert property (tk && op == OP_HALT |=> POWER_DOWN_OUT && WDT_CLEAR_OUT
      && !READY_OUT) else $error("halt");
   chk_wdog_pulse:
   assert property (tk && op == OP_WDOG_CLR |=> WDT_CLEAR_OUT) else $error("wdog clear");
   chk_nop_step:
   assert property (tk && op == OP_NOP |=> READY_OUT
      && PC_OUT == $past(PC_OUT) + 11'h1) else $error("nop");
   chk_pcl_write:
   assert property (tk && pw |=> !READY_OUT ##1 READY_OUT) else $error("pcl write");
   cover property (tk && op == OP_CALL);
   cover property (tk && op == OP_TBL_CUR);
   cover property (tk && op == OP_WDOG_PC2);
endmodule
`default_nettype wire

/* verif/instr_exec_tb.sv */
`default_nettype none
module instr_exec_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import instr_exec_pkg::*;
   logic            clk = 0;
   logic            rst_b = 0;
   logic            vld = 0;
   logic [OP_W-1:0] op = OP_NOP;
   logic [6:0]      ad = 7'h00;
   logic [7:0]      imm = 8'h00;
   logic [PC_W-1:0] tgt = 11'h000;
   logic            wake = 0;
   logic [6:0]      ra = 7'h00;
   logic [7:0]      wd = 8'h00;
   logic            wr = 0;
   logic            rd = 0;
   logic [PC_W-1:0] pc;
   logic [PC_W-1:0] p;
   logic [7:0]      rdat;
   logic            rdy;
   logic            pd;
   logic            ie;
   int              error_cnt = 0;
   int              checked = 0;
   int              n;
   initial forever #50 clk = ~clk;
   // Fixed program word: low byte and high part differ
   instr_exec dut (
      .CLK_IN(clk), .RST_B_IN(rst_b), .INSTR_VALID_IN(vld), .INSTR_OP_IN(op),
      .INSTR_ADDR_IN(ad), .INSTR_IMM_IN(imm), .INSTR_TARGET_IN(tgt),
      .TABLE_DATA_IN(15'h2abc), .WAKE_IN(wake), .REG_ADDR_IN(ra),
      .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .PC_OUT(pc),
      .READY_OUT(rdy), .TABLE_RD_OUT(), .TABLE_ADDR_OUT(), .WDT_CLEAR_OUT(),
      .POWER_DOWN_OUT(pd), .INT_ENABLE_OUT(ie), .REG_RDATA_OUT(rdat));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic results;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrdy;
      while (rdy !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 20) begin
         error_cnt++;
         results;
      end
   endtask
   // Valid stays up so one-cycle ops run back to back
   task automatic ex(input logic [OP_W-1:0] o, input logic [6:0] a = 7'h00,
                     input logic [7:0] i = 8'h00);
      vld <= 1'b1;
      op <= o;
      ad <= a;
      imm <= i;
      n = 1;
      @(posedge clk);
      #1;
      wrdy;
   endtask
   task automatic rw(input logic [6:0] a, input logic [7:0] d);
      vld <= 1'b0;
      wr <= 1'b1;
      ra <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rchk(input logic [6:0] a, input logic [7:0] e);
      vld <= 1'b0;
      rd <= 1'b1;
      ra <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      cmp(rdat, e);
   endtask
   task automatic hw;
      vld <= 1'b1;
      op <= OP_HALT;
      @(posedge clk);
      vld <= 1'b0;
      #1;
      cmp(pd, 1);
      wake <= 1'b1;
      n = 0;
      wrdy;
      wake <= 1'b0;
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      rchk(STATUS_ADDR, 8'h00);
      rw(ACC_ADDR, 8'hf0);
      rw(7'h10, 8'h3c);
      ex(OP_ANDA, 7'h10);
      rchk(ACC_ADDR, 8'h30);
      ex(OP_AND_TO_MEMORY_INSTR, 7'h10);
      rchk(7'h10, 8'h30);
      ex(OP_ANDI, 7'h00, 8'h0f);
      rchk(STATUS_ADDR, 8'h04);
      rw(ACC_ADDR, 8'h88);
      rw(7'h11, 8'h88);
      ex(OP_ADDA, 7'h11);
      rchk(STATUS_ADDR, 8'h0b);
      ex(OP_ADCA, 7'h11);
      rchk(ACC_ADDR, 8'h99);
      ex(OP_ADDI, 7'h00, 8'h67);
      rchk(STATUS_ADDR, 8'h07);
      ex(OP_ADD_CARRY_TO_MEMORY_INSTR, 7'h11);
      rchk(7'h11, 8'h89);
      rw(ACC_ADDR, 8'h77);
      ex(OP_ADD_TO_MEMORY_INSTR, 7'h11);
      rchk(STATUS_ADDR, 8'h07);
      ex(OP_SWAP_ACC, 7'h10);
      rchk(ACC_ADDR, 8'h03);
      rw(7'h12, 8'hff);
      p = pc;
      ex(OP_INC_SKIP, 7'h12);
      cmp(n, 2);
      cmp(pc, p + 11'h2);
      ex(OP_INC_SKIP, 7'h10);
      cmp(n, 1);
      rchk(ACC_ADDR, 8'h31);
      rw(7'h12, 8'h01);
      ex(OP_DEC_SKIP, 7'h12);
      cmp(n, 2);
      rchk(STATUS_ADDR, 8'h07);
      p = pc;
      tgt <= 11'h123;
      ex(OP_CALL);
      cmp(pc, 16'h0123);
      ex(OP_RET_IMM, 7'h00, 8'h5a);
      cmp(pc, p + 11'h1);
      rchk(ACC_ADDR, 8'h5a);
      for (int k = 0; k < 2; k++) begin
         p = pc;
         ex(OP_CALL);
         ex(k ? OP_INT_RET : OP_RET);
         cmp(pc, p + 11'h1);
      end
      cmp(ie, 1);
      ex(OP_TBL_LAST, 7'h13, 8'h45);
      rchk(TABLE_HIGH_BYTE_ADDR, 8'h2a);
      ex(OP_TBL_CUR, 7'h14, 8'h46);
      rchk(7'h14, 8'hbc);
      ex(OP_CLR_MEM, 7'h14);
      rchk(7'h14, 8'h00);
      ex(OP_CLR_MEM, PCL_ADDR);
      cmp(n, 2);
      hw;
      rchk(STATUS_ADDR, 8'h17);
      ex(OP_WDOG_PC1);
      ex(OP_NOP);
      ex(OP_WDOG_PC2);
      rchk(STATUS_ADDR, 8'h17);
      ex(OP_WDOG_PC1);
      ex(OP_WDOG_PC2);
      rchk(STATUS_ADDR, 8'h07);
      hw;
      ex(OP_WDOG_CLR);
      rchk(STATUS_ADDR, 8'h07);
      results;
   end
endmodule
bind instr_exec instr_exec_asserts u_chk (.*);
`default_nettype wire
